// ===== inc/anvc_defines.vh
// Constants for the nonvolatile RAM host controller
`ifndef ANVC_DEFINES_VH
`define ANVC_DEFINES_VH
// ----------------------------------------
// Command register map
// ----------------------------------------
`define ANVC_REG_ADDR 4'h0
`define ANVC_REG_WDATA 4'h1
`define ANVC_REG_CMD 4'h2
`define ANVC_REG_STATUS 4'h3
`define ANVC_REG_RDATA 4'h4
`define ANVC_REG_PROT 4'h5
`define ANVC_REG_SLEEP 4'h6
// ----------------------------------------
// Command codes and field positions
// ----------------------------------------
`define ANVC_CMD_READ 3'h1
`define ANVC_CMD_WRITE 3'h2
`define ANVC_CMD_PROTECT 3'h3
`define ANVC_CMD_PAGE_READ 3'h4
`define ANVC_CMD_PAGE_WRITE 3'h5
`define ANVC_CMD_CLOSE 3'h6
`define ANVC_CMD_UB_BIT 4
`define ANVC_CMD_LB_BIT 5
`define ANVC_STAT_BUSY_BIT 0
`define ANVC_STAT_OPEN_BIT 1
`define ANVC_STAT_AWAKE_BIT 2
// ----------------------------------------
// Timing, in ns, and derived cycles at 10 ns
// ----------------------------------------
`define ANVC_CLK_PERIOD_NS 10
`define ANVC_ACCESS_TIME_NS 60
`define ANVC_PAGE_ACCESS_TIME_NS 30
`define ANVC_WRITE_PULSE_NS 60
`define ANVC_PRECHARGE_TIME_NS 60
`define ANVC_WAKE_DELAY_NS 450000
`define ANVC_CYC(ns) (((ns) + `ANVC_CLK_PERIOD_NS - 1) / `ANVC_CLK_PERIOD_NS)
// ----------------------------------------
// Unlock address sequence
// ----------------------------------------
`define ANVC_UNLOCK_A0 18'h2_4555
`define ANVC_UNLOCK_A1 18'h3_AAAA
`define ANVC_UNLOCK_A2 18'h0_2333
`define ANVC_UNLOCK_A3 18'h1_CCCC
`define ANVC_UNLOCK_A4 18'h0_00FF
`define ANVC_UNLOCK_A5 18'h3_EF00
`define ANVC_UNLOCK_W0 18'h3_AAAA
`define ANVC_UNLOCK_W1 18'h1_CCCC
`define ANVC_UNLOCK_W2 18'h0_FF00
`define ANVC_UNLOCK_RD 18'h0_0000
`define ANVC_SEQ_LEN 4'hA
`endif

// ===== src/anvc_timer.v
// Down-counter for minimum pin times
`timescale 1ns/10ps
`default_nettype none
module anvc_timer #(
	parameter W = 16
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire resetn_i,
	// Load and status
	input wire load_i,
	input wire [W-1:0] count_i,
	output reg done_o
);
	reg [W-1:0] cnt;
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt <= {W{1'b0}};
			done_o <= 1'b1;
		end else if (load_i) begin
			cnt <= count_i;
			done_o <= 1'b0;
		end else if (cnt > {{(W-1){1'b0}}, 1'b1}) begin
			cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
		end else begin
			cnt <= {W{1'b0}};
			done_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== src/anvc_unlock_rom.v
// Address, kind and data source of each unlock step
`timescale 1ns/10ps
`default_nettype none
`include "anvc_defines.vh"
module anvc_unlock_rom (
	// Step index
	input wire [3:0] step_i,
	// Step description
	output reg [17:0] addr_o,
	output reg is_write_o,
	output reg use_compl_o
);
	always @* begin
		is_write_o = 1'b0;
		use_compl_o = 1'b0;
		case (step_i)
			4'h0: addr_o = `ANVC_UNLOCK_A0;
			4'h1: addr_o = `ANVC_UNLOCK_A1;
			4'h2: addr_o = `ANVC_UNLOCK_A2;
			4'h3: addr_o = `ANVC_UNLOCK_A3;
			4'h4: addr_o = `ANVC_UNLOCK_A4;
			4'h5: addr_o = `ANVC_UNLOCK_A5;
			4'h6: begin
				addr_o = `ANVC_UNLOCK_W0;
				is_write_o = 1'b1;
			end
			4'h7: begin
				addr_o = `ANVC_UNLOCK_W1;
				is_write_o = 1'b1;
				use_compl_o = 1'b1;
			end
			4'h8: begin
				addr_o = `ANVC_UNLOCK_W2;
				is_write_o = 1'b1;
			end
			default: addr_o = `ANVC_UNLOCK_RD;
		endcase
	end
endmodule
`default_nettype wire

// ===== src/anvc_host.v
// Host controller driving an asynchronous nonvolatile RAM
// Operation
// - Host keeps chip select high for the precharge time between accesses; host holds it low while a row is open, raising it only on close.
// - Host holds valid write data when write strobe rises.
// - Host gives each write its own write strobe pulse.
// - Host finishes accesses before sleep; waits wake delay after release.
// - Protection change: six reads, mask write, complement write, zero write, one read.
// - Fixed unlock read, write and final read addresses.
// - With chip select low at start, host first accesses address zero.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "anvc_defines.vh"
module anvc_host #(
	parameter WAKE_CYCLES = `ANVC_CYC(`ANVC_WAKE_DELAY_NS)
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire resetn_i,
	// Register port
	input wire [3:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [15:0] reg_rdata_o,
	// Memory pins
	output reg [17:0] mem_addr_o,
	output reg chip_sel_n_o,
	output reg write_strobe_n_o,
	output reg output_drive_n_o,
	output reg upper_byte_sel_n_o,
	output reg lower_byte_sel_n_o,
	output reg sleep_request_n_o,
	input wire [15:0] data_lines_i,
	output reg [15:0] data_lines_o,
	output reg data_lines_oe_o
);
	// ----------------------------------------
	// Timing counts
	// ----------------------------------------
	localparam [15:0] ACC_CYC = `ANVC_CYC(`ANVC_ACCESS_TIME_NS);
	localparam [15:0] PAGE_CYC = `ANVC_CYC(`ANVC_PAGE_ACCESS_TIME_NS);
	localparam [15:0] WR_CYC = `ANVC_CYC(`ANVC_WRITE_PULSE_NS);
	localparam [15:0] PC_CYC = `ANVC_CYC(`ANVC_PRECHARGE_TIME_NS);
	localparam [31:0] WAKE_CNT = WAKE_CYCLES;
	// ----------------------------------------
	// States, one-hot
	// ----------------------------------------
	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_RD = 7'h02;
	localparam [6:0] S_WR = 7'h04;
	localparam [6:0] S_WEND = 7'h08;
	localparam [6:0] S_PC = 7'h10;
	localparam [6:0] S_SLEEP = 7'h20;
	localparam [6:0] S_WAKE = 7'h40;
	reg [6:0] state;
	reg [17:0] addr_reg;
	reg [15:0] wdata_reg;
	reg [15:0] rdata_reg;
	reg [7:0] prot_mask;
	reg busy;
	reg row_open;
	reg unlock_mode;
	reg [3:0] step;
	reg sleep_req;
	reg awake;
	reg [31:0] wake_cnt;
	reg tmr_load;
	reg [15:0] tmr_count;
	wire tmr_done;
	wire [17:0] rom_addr;
	wire rom_write;
	wire rom_compl;
	wire start_cmd;
	wire rd_cmd;
	anvc_timer #(
		.W(16)
	) u_timer (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.load_i(tmr_load),
		.count_i(tmr_count),
		.done_o(tmr_done)
	);
	anvc_unlock_rom u_rom (
		.step_i(step + 4'h1),
		.addr_o(rom_addr),
		.is_write_o(rom_write),
		.use_compl_o(rom_compl)
	);
	// Codes 0 and 7 refused, not run as writes
	assign start_cmd = reg_wr_i && (reg_addr_i == `ANVC_REG_CMD) && !busy && awake
		&& reg_wdata_i[2:0] != 3'h0 && reg_wdata_i[2:0] != 3'h7;
	assign rd_cmd = reg_wdata_i[2:0] == `ANVC_CMD_READ
		|| reg_wdata_i[2:0] == `ANVC_CMD_PAGE_READ;
	// Row part of the address differs from the open row
	function row_change;
		input [17:0] a;
		input [17:0] b;
		begin
			row_change = (a[17:2] != b[17:2]);
		end
	endfunction
	// ----------------------------------------
	// Register reads, data one cycle later
	// ----------------------------------------
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`ANVC_REG_ADDR: reg_rdata_o <= addr_reg[15:0];
				`ANVC_REG_WDATA: reg_rdata_o <= wdata_reg;
				`ANVC_REG_STATUS: reg_rdata_o <= {13'h0000, awake, row_open, busy};
				`ANVC_REG_RDATA: reg_rdata_o <= rdata_reg;
				`ANVC_REG_PROT: reg_rdata_o <= {8'h00, prot_mask};
				`ANVC_REG_SLEEP: reg_rdata_o <= {15'h0000, sleep_req};
				default: reg_rdata_o <= 16'h0000;
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= S_IDLE;
			addr_reg <= 18'h0_0000;
			wdata_reg <= 16'h0000;
			rdata_reg <= 16'h0000;
			prot_mask <= 8'h00;
			busy <= 1'b0;
			row_open <= 1'b0;
			unlock_mode <= 1'b0;
			step <= 4'h0;
			sleep_req <= 1'b0;
			awake <= 1'b1;
			wake_cnt <= 32'h0000_0000;
			tmr_load <= 1'b0;
			tmr_count <= 16'h0000;
			mem_addr_o <= 18'h0_0000;
			chip_sel_n_o <= 1'b1;
			write_strobe_n_o <= 1'b1;
			output_drive_n_o <= 1'b1;
			upper_byte_sel_n_o <= 1'b1;
			lower_byte_sel_n_o <= 1'b1;
			sleep_request_n_o <= 1'b1;
			data_lines_o <= 16'h0000;
			data_lines_oe_o <= 1'b0;
		end else begin
			tmr_load <= 1'b0;
			if (reg_wr_i && reg_addr_i == `ANVC_REG_ADDR) begin
				addr_reg <= {2'b00, reg_wdata_i};
			end
			if (reg_wr_i && reg_addr_i == `ANVC_REG_WDATA) begin
				wdata_reg <= reg_wdata_i;
			end
			if (reg_wr_i && reg_addr_i == `ANVC_REG_PROT) begin
				addr_reg[17:16] <= reg_wdata_i[1:0];
			end
			if (reg_wr_i && reg_addr_i == `ANVC_REG_SLEEP) begin
				sleep_req <= reg_wdata_i[0];
			end
			case (state)
				S_IDLE: begin
					if (sleep_req && !busy && !row_open) begin
						sleep_request_n_o <= 1'b0;
						awake <= 1'b0;
						state <= S_SLEEP;
					end else if (start_cmd) begin
						busy <= 1'b1;
						upper_byte_sel_n_o <= !reg_wdata_i[`ANVC_CMD_UB_BIT];
						lower_byte_sel_n_o <= !reg_wdata_i[`ANVC_CMD_LB_BIT];
						if (reg_wdata_i[2:0] == `ANVC_CMD_CLOSE) begin
							chip_sel_n_o <= 1'b1;
							row_open <= 1'b0;
							tmr_load <= 1'b1;
							tmr_count <= PC_CYC;
							state <= S_PC;
						end else if (reg_wdata_i[2:0] == `ANVC_CMD_PROTECT) begin
							// Address zero first if the row is still open
							unlock_mode <= 1'b1;
							step <= 4'h0;
							upper_byte_sel_n_o <= 1'b0;
							lower_byte_sel_n_o <= 1'b0;
							if (row_open) begin
								mem_addr_o <= `ANVC_UNLOCK_RD;
								output_drive_n_o <= 1'b0;
								tmr_load <= 1'b1;
								tmr_count <= ACC_CYC;
								step <= 4'hF;
								state <= S_RD;
							end else begin
								mem_addr_o <= `ANVC_UNLOCK_A0;
								chip_sel_n_o <= 1'b0;
								row_open <= 1'b1;
								output_drive_n_o <= 1'b0;
								tmr_load <= 1'b1;
								tmr_count <= ACC_CYC;
								state <= S_RD;
							end
						end else begin
							mem_addr_o <= addr_reg;
							chip_sel_n_o <= 1'b0;
							row_open <= 1'b1;
							tmr_load <= 1'b1;
							if (rd_cmd) begin
								output_drive_n_o <= 1'b0;
								if (row_open && !row_change(addr_reg, mem_addr_o)) begin
									tmr_count <= PAGE_CYC;
								end else begin
									tmr_count <= ACC_CYC;
								end
								state <= S_RD;
							end else begin
								output_drive_n_o <= 1'b1;
								write_strobe_n_o <= 1'b0;
								data_lines_o <= wdata_reg;
								data_lines_oe_o <= 1'b1;
								tmr_count <= WR_CYC;
								state <= S_WR;
							end
						end
					end
				end
				S_RD: begin
					if (tmr_done && !tmr_load) begin
						rdata_reg <= data_lines_i;
						output_drive_n_o <= 1'b1;
						if (unlock_mode && step != 4'h9) begin
							step <= step + 4'h1;
							mem_addr_o <= rom_addr;
							// Next step is a read until the six are done
							if (rom_write) begin
								data_lines_o <= {8'h00, wdata_reg[7:0]};
								data_lines_oe_o <= 1'b1;
								write_strobe_n_o <= 1'b0;
								tmr_load <= 1'b1;
								tmr_count <= WR_CYC;
								state <= S_WR;
							end else begin
								output_drive_n_o <= 1'b0;
								tmr_load <= 1'b1;
								tmr_count <= ACC_CYC;
							end
						end else begin
							if (unlock_mode) begin
								prot_mask <= wdata_reg[7:0];
							end
							unlock_mode <= 1'b0;
							busy <= 1'b0;
							state <= S_IDLE;
						end
					end
				end
				S_WR: begin
					if (tmr_done && !tmr_load) begin
						write_strobe_n_o <= 1'b1;
						tmr_load <= 1'b1;
						tmr_count <= 16'h0001;
						state <= S_WEND;
					end
				end
				S_WEND: begin
					// Data held three cycles past the strobe rise
					if (tmr_done && !tmr_load) begin
						data_lines_oe_o <= 1'b0;
						if (unlock_mode && rom_write) begin
							step <= step + 4'h1;
							mem_addr_o <= rom_addr;
							data_lines_o <= rom_compl ?
								{8'h00, ~wdata_reg[7:0]} : 16'h0000;
							data_lines_oe_o <= 1'b1;
							write_strobe_n_o <= 1'b0;
							tmr_load <= 1'b1;
							tmr_count <= WR_CYC;
							state <= S_WR;
						end else if (unlock_mode) begin
							step <= 4'h9;
							mem_addr_o <= `ANVC_UNLOCK_RD;
							output_drive_n_o <= 1'b0;
							tmr_load <= 1'b1;
							tmr_count <= ACC_CYC;
							state <= S_RD;
						end else begin
							busy <= 1'b0;
							state <= S_IDLE;
						end
					end
				end
				S_PC: begin
					if (tmr_done && !tmr_load) begin
						busy <= 1'b0;
						state <= S_IDLE;
					end
				end
				S_SLEEP: begin
					if (!sleep_req) begin
						sleep_request_n_o <= 1'b1;
						wake_cnt <= WAKE_CNT;
						state <= S_WAKE;
					end
				end
				S_WAKE: begin
					if (wake_cnt > 32'h0000_0001) begin
						wake_cnt <= wake_cnt - 32'h0000_0001;
					end else begin
						awake <= 1'b1;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== verification/anvc_host_properties.sv
// Pin-level and register-port assertions for the nonvolatile RAM host controller
`timescale 1ns/10ps
`default_nettype none
module anvc_host_checker #(
	parameter WAKE_CYCLES = 20
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	// Memory pins
	input wire logic [17:0] mem_addr_o,
	input wire logic chip_sel_n_o,
	input wire logic write_strobe_n_o,
	input wire logic output_drive_n_o,
	input wire logic upper_byte_sel_n_o,
	input wire logic lower_byte_sel_n_o,
	input wire logic sleep_request_n_o,
	input wire logic [15:0] data_lines_i,
	input wire logic [15:0] data_lines_o,
	input wire logic data_lines_oe_o
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	int wake_cnt;
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wake_cnt <= WAKE_CYCLES;
		end else if (!sleep_request_n_o) begin
			wake_cnt <= 0;
		end else if (wake_cnt < WAKE_CYCLES) begin
			wake_cnt <= wake_cnt + 1;
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence seq_write_held;
		(!write_strobe_n_o && data_lines_oe_o && $stable(data_lines_o)
			&& $stable(mem_addr_o))[*5];
	endsequence
	sequence seq_precharge;
		chip_sel_n_o[*6];
	endsequence
	AST_WRITE_PULSE: assert property ($fell(write_strobe_n_o) |=> seq_write_held)
		else $error("Write pulse short or data moved");
	AST_PRECHARGE: assert property ($rose(chip_sel_n_o) |-> seq_precharge)
		else $error("Chip select high too briefly");
	AST_HOST_QUIET: assert property (data_lines_oe_o |-> output_drive_n_o)
		else $error("Host drives while output drive low");
	AST_DRIVE_READ: assert property (!output_drive_n_o |-> write_strobe_n_o)
		else $error("Output drive low during write");
	AST_STROBE_SEL: assert property (!write_strobe_n_o |-> !chip_sel_n_o)
		else $error("Write strobe outside chip select");
	AST_SLEEP_IDLE: assert property (!sleep_request_n_o |-> chip_sel_n_o && write_strobe_n_o)
		else $error("Access while asleep");
	AST_WAKE_WAIT: assert property ($fell(chip_sel_n_o) |-> wake_cnt >= WAKE_CYCLES - 1)
		else $error("Access before wake delay");
	AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
		else $error("Read data outside its cycle");
endmodule
bind anvc_host anvc_host_checker #(.WAKE_CYCLES(WAKE_CYCLES)) u_checker (
	.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o), .chip_sel_n_o(chip_sel_n_o),
	.write_strobe_n_o(write_strobe_n_o), .output_drive_n_o(output_drive_n_o),
	.upper_byte_sel_n_o(upper_byte_sel_n_o), .lower_byte_sel_n_o(lower_byte_sel_n_o),
	.sleep_request_n_o(sleep_request_n_o), .data_lines_i(data_lines_i),
	.data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o));
`default_nettype wire

// ===== verification/anvc_nvram_model.sv
// Behavioural model of the word-wide nonvolatile RAM
`timescale 1ns/10ps
`default_nettype none
module anvc_nvram_model #(
	parameter int ACC = 55,
	parameter int PG = 25
) (
	// Pins from the host
	input wire logic [17:0] addr_i,
	input wire logic ce_n_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic upper_n_i,
	input wire logic lower_n_i,
	input wire logic sleep_n_i,
	input wire logic [15:0] dq_i,
	// Read drive
	output logic [15:0] dq_o,
	output logic [1:0] dq_en_o
);
	// ----------------------------------------
	// Array, mask and unlock tracking
	// ----------------------------------------
	logic [15:0] mem [int];
	logic [17:0] seq [6] = '{18'h2_4555, 18'h3_AAAA, 18'h0_2333, 18'h1_CCCC, 18'h0_00FF,
		18'h3_EF00};
	logic [7:0] mask = 8'h00;
	logic [7:0] pend;
	logic [17:0] la = 18'h0_0000;
	logic [15:0] wd;
	logic [1:0] wb;
	logic pce = 1'h1;
	logic pwe = 1'h1;
	logic wrote = 1'h0;
	logic dv = 1'h0;
	int st = 0;
	realtime vt = 0;
	function automatic logic [15:0] rdw(input logic [17:0] a);
		return mem.exists(a) ? mem[a] : 16'h0000;
	endfunction
	// Counted when a read access ends, so row-open hosts work too
	task automatic rd_op(input logic [17:0] a);
		if (st < 6 && a == seq[st]) st++;
		else if (st == 9 && a == 18'h0_0000) st = 0;
		else st = (a == seq[0]);
	endtask
	task automatic wr_op(input logic [17:0] a, input logic [15:0] d);
		logic [15:0] o;
		o = rdw(a);
		wrote = 1'h1;
		if (st == 6) begin
			pend = d[7:0];
			st = 7;
		end else if (st == 7 && d[7:0] == ~pend) begin
			mask = pend;
			st = 8;
		end else if (st == 8 && a == 18'h0_FF00) begin
			st = 9;
		end else begin
			st = 0;
			if (!mask[a[17:15]]) mem[a] = {wb[1] ? o[15:8] : d[15:8], wb[0] ? o[7:0] : d[7:0]};
		end
	endtask
	// Pins are sampled every nanosecond, fine enough for a 10 ns host
	always #1 begin
		if (!sleep_n_i) begin
			pce = 1'h1;
			pwe = 1'h1;
		end else begin
			if (!pwe && (we_n_i || ce_n_i)) wr_op(la, wd);
			if (!pce && (ce_n_i || addr_i != la) && !wrote) rd_op(la);
			if (!ce_n_i && (pce || addr_i != la)) begin
				vt = $realtime + ((pce || addr_i[17:2] != la[17:2]) ? ACC : PG);
				la = addr_i;
				wrote = 1'h0;
			end
			if (!we_n_i && !ce_n_i) begin
				wd = dq_i;
				wb = {upper_n_i, lower_n_i};
			end
			pce = ce_n_i;
			pwe = we_n_i | ce_n_i;
		end
		dq_o = rdw(la);
		dv = sleep_n_i && !ce_n_i && we_n_i && !oe_n_i && ($realtime >= vt);
	end
	assign dq_en_o = {2{dv}} & ~{upper_n_i, lower_n_i};
endmodule
`default_nettype wire

// ===== verification/test_anvc_host.sv
// Self-checking bench for the nonvolatile RAM host controller
`timescale 1ns/10ps
`default_nettype none
module test_anvc_host;
	localparam int WAKE = 20;
	logic sys_clk_i = 1'h0;
	logic resetn_i = 1'h0;
	logic [3:0] ra = 4'h0;
	logic [15:0] rw = 16'h0000;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [15:0] pat = 16'h5A5A;
	logic [15:0] rdata, hdo, mdo, dq;
	logic [17:0] ma;
	logic cs, we, od, upper_n, lower_n, sleep_n, hoe;
	logic [1:0] men;
	int bad_count = 0;
	int checks_done = 0;
	// Undriven lines toggle, so a stale value cannot pass
	assign dq = hoe ? hdo : {men[1] ? mdo[15:8] : pat[15:8], men[0] ? mdo[7:0] : pat[7:0]};
	always @(posedge sys_clk_i) pat <= ~pat;
	initial forever #5 sys_clk_i = ~sys_clk_i;
	anvc_host #(.WAKE_CYCLES(WAKE)) uut (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(ra), .reg_wdata_i(rw),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .mem_addr_o(ma),
		.chip_sel_n_o(cs), .write_strobe_n_o(we), .output_drive_n_o(od),
		.upper_byte_sel_n_o(upper_n), .lower_byte_sel_n_o(lower_n),
		.sleep_request_n_o(sleep_n), .data_lines_i(dq), .data_lines_o(hdo),
		.data_lines_oe_o(hoe));
	anvc_nvram_model u_mem (
		.addr_i(ma), .ce_n_i(cs), .we_n_i(we), .oe_n_i(od), .upper_n_i(upper_n),
		.lower_n_i(lower_n), .sleep_n_i(sleep_n), .dq_i(dq), .dq_o(mdo), .dq_en_o(men));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		ra <= a;
		rw <= d;
		wr <= 1'h1;
		@(posedge sys_clk_i);
		wr <= 1'h0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		ra <= a;
		rd <= 1'h1;
		@(posedge sys_clk_i);
		rd <= 1'h0;
		#1 d = rdata;
	endtask
	// Bounded poll of one status bit
	task automatic wait_stat(input int b, input logic v);
		logic [15:0] s;
		for (int i = 0; i < 400; i++) begin
			rreg(4'h3, s);
			if (s[b] === v) return;
		end
		bad_count++;
		complete_run();
	endtask
	task automatic op(input logic [5:0] c, input logic [17:0] a, input logic [15:0] d);
		wreg(4'h0, a[15:0]);
		wreg(4'h5, {14'h0000, a[17:16]});
		wreg(4'h1, d);
		wreg(4'h2, {10'h000, c});
		wait_stat(0, 1'h0);
	endtask
	task automatic rdchk(input logic [17:0] a, input logic [15:0] exp);
		logic [15:0] v;
		op(6'h31, a, 16'h0000);
		rreg(4'h4, v);
		cmp(v, exp);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [15:0] s;
		rreg(4'h3, s);
		cmp({13'h0000, s[2:0]}, 16'h0004);
		cmp({14'h0000, cs, sleep_n}, 16'h0003);
	endtask
	task automatic t_rw();
		logic [15:0] s;
		op(6'h32, 18'h0_1235, 16'hA55A);
		op(6'h35, 18'h0_1236, 16'h1111);
		op(6'h12, 18'h0_1235, 16'h7700);
		rdchk(18'h0_1235, 16'h775A);
		rdchk(18'h0_1236, 16'h1111);
		op(6'h34, 18'h0_1235, 16'h0000);
		rreg(4'h4, s);
		cmp(s, 16'h775A);
		op(6'h32, 18'h2_0004, 16'h0F0F);
		rdchk(18'h2_0004, 16'h0F0F);
		op(6'h06, 18'h0_0000, 16'h0000);
		rreg(4'h3, s);
		cmp({14'h0000, s[1:0]}, 16'h0000);
	endtask
	task automatic t_prot();
		logic [15:0] s;
		op(6'h32, 18'h3_AAAA, 16'h4321);
		op(6'h33, 18'h0_0000, 16'h0018);
		rreg(4'h5, s);
		cmp({8'h00, s[7:0]}, 16'h0018);
		cmp({8'h00, u_mem.mask}, 16'h0018);
		op(6'h32, 18'h1_8000, 16'hBEEF);
		rdchk(18'h1_8000, 16'h0000);
		op(6'h32, 18'h0_7FFF, 16'h1234);
		rdchk(18'h0_7FFF, 16'h1234);
		rdchk(18'h3_AAAA, 16'h4321);
		op(6'h33, 18'h0_0000, 16'h0000);
		op(6'h32, 18'h1_8000, 16'hBEEF);
		rdchk(18'h1_8000, 16'hBEEF);
	endtask
	task automatic t_sleep();
		logic [15:0] s;
		op(6'h06, 18'h0_0000, 16'h0000);
		wreg(4'h6, 16'h0001);
		wreg(4'h2, 16'h0031);
		rreg(4'h3, s);
		cmp({12'h000, cs, s[2:0]}, 16'h0008);
		wreg(4'h6, 16'h0000);
		wait_stat(2, 1'h1);
		rdchk(18'h0_1236, 16'h1111);
	endtask
	initial begin
		repeat (4) @(posedge sys_clk_i);
		resetn_i <= 1'h1;
		t_reset();
		t_rw();
		t_prot();
		t_sleep();
		complete_run();
	end
endmodule
`default_nettype wire
